//--- verilog/ttp_pkg.sv
// Package of constants for the two-thread pipeline sharing control
package ttp_pkg;
  // ==========================================================
  // Thread count and buffer sizes
  localparam int NUM_THREADS = 2;
  localparam int STREAM_BUF_ENTRIES = 2;
  localparam int UOPQ_ENTRIES = 16;
  localparam int RENQ_ENTRIES = 16;
  localparam int ROB_ENTRIES = 32;
  localparam int LDB_ENTRIES = 16;
  localparam int STB_ENTRIES = 16;
  localparam int DISPATCH_MAX = 6;
  localparam int XLAT_ENTRIES = 8;
  localparam int IP_WIDTH = 32;
  localparam int PAGE_WIDTH = 20;
  // ==========================================================
  // Reset values
  localparam logic [31:0] IP_RESET = 32'h0000_0000;
  localparam logic RR_RESET = 1'h0;
  // ==========================================================
  // Data cache sharing modes, chosen by the context identifier bit
  typedef enum logic [0:0] {
    TTP_DC_SHARED = 1'h0,
    TTP_DC_ADAPTIVE = 1'h1
  } ttp_dcmode_e;
  // Buffer indices used in occupancy vectors
  localparam int BUF_UOPQ = 0;
  localparam int BUF_RENQ = 1;
  localparam int BUF_ROB = 2;
  localparam int BUF_LDB = 3;
  localparam int BUF_STB = 4;
  localparam int NUM_BUFS = 5;
endpackage

//--- verilog/ttp_pipe_share.sv
// Two-thread pipeline sharing control: replicated state, partition caps, thread selection
// Behaviour
// - Architectural state is kept per thread; execution resources are one shared set.
// - Each thread has its own instruction pointer and renaming table.
// - Return address stack exists once per thread, never disturbed by the other.
// - Each thread owns a private two-entry instruction streaming buffer.
// - Partitioned buffers cap each thread's occupancy at half the entries; the micro-op queue only while both threads are active.
// - Caps cover micro-op queue, rename queues, reorder buffer, load and store buffers.
// - Load/store ordering violations are detected within each thread's own half.
// - Translation buffer entries carry thread bit; lookups hit only matching thread.
// - Context bit picks shared or adaptive data cache mode.
// - Every selection point alternates; an unable thread yields its cycle.
// - Trace cache arbitrated each clock, alternating when both request.
// - A stalled thread gives full trace cache bandwidth to the other.
// - Micro-op queue is split between threads whenever both are active.
// - Dispatch at most six ready micro-ops, blind to thread.
// - Retirement in order per thread, alternating; idle thread gives all to other.
// - Store commit to the data cache alternates between threads.
`timescale 1ns/100ps
module ttp_pipe_share #(
  parameter int RAS_DEPTH = 8,
  parameter int RENAME_REGS = 8,
  parameter int PREG_WIDTH = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Per-thread stage requests and not-ready indications
  input wire logic [1:0] fetchReq,
  input wire logic [1:0] fetchNotReady,
  input wire logic [1:0] retireReady,
  input wire logic [1:0] retireNotReady,
  input wire logic [1:0] storeReady,
  input wire logic [1:0] storeNotReady,
  // Thread activity
  input wire logic [1:0] threadActive,
  // Instruction pointer updates
  input wire logic [1:0] ipLoad,
  input wire logic [ttp_pkg::IP_WIDTH-1:0] ipLoadValue,
  // Return stack per thread: push with address, pop
  input wire logic [1:0] rasPush,
  input wire logic [1:0] rasPop,
  input wire logic [ttp_pkg::IP_WIDTH-1:0] rasPushAddr,
  // Rename table write
  input wire logic renWrite,
  input wire logic renThread,
  input wire logic [2:0] renArch,
  input wire logic [PREG_WIDTH-1:0] renPhys,
  // Rename table read
  input wire logic renRdThread,
  input wire logic [2:0] renRdArch,
  // Buffer allocate/free per thread, one bit per buffer
  input wire logic [ttp_pkg::NUM_BUFS-1:0] allocReq0,
  input wire logic [ttp_pkg::NUM_BUFS-1:0] allocReq1,
  input wire logic [ttp_pkg::NUM_BUFS-1:0] freeReq0,
  input wire logic [ttp_pkg::NUM_BUFS-1:0] freeReq1,
  // Streaming buffer push/pop per thread
  input wire logic [1:0] sbPush,
  input wire logic [1:0] sbPop,
  // Memory ordering check: load address against older stores per thread
  input wire logic [1:0] ordViolIn,
  // Translation buffer fill and lookup
  input wire logic xlatFill,
  input wire logic xlatFillThread,
  input wire logic [ttp_pkg::PAGE_WIDTH-1:0] xlatFillPage,
  input wire logic xlatLookup,
  input wire logic xlatLookupThread,
  input wire logic [ttp_pkg::PAGE_WIDTH-1:0] xlatLookupPage,
  // Data cache mode select
  input wire logic contextIdBit,
  // Dispatch: ready micro-ops count from the shared scheduler
  input wire logic [3:0] readyUops,
  // Selection outputs
  output logic fetchGrant,
  output logic fetchThread,
  output logic retireGrant,
  output logic retireThread,
  output logic storeGrant,
  output logic storeThread,
  // Per-thread state outputs
  output logic [ttp_pkg::IP_WIDTH-1:0] ip0,
  output logic [ttp_pkg::IP_WIDTH-1:0] ip1,
  output logic [ttp_pkg::IP_WIDTH-1:0] rasTop0,
  output logic [ttp_pkg::IP_WIDTH-1:0] rasTop1,
  output logic [PREG_WIDTH-1:0] renRdPhys,
  // Buffer admission per thread
  output logic [ttp_pkg::NUM_BUFS-1:0] allocOk0,
  output logic [ttp_pkg::NUM_BUFS-1:0] allocOk1,
  output logic [1:0] sbFull,
  output logic [1:0] ordViolation,
  // Translation and cache mode
  output logic xlatHit,
  output logic dcAdaptive,
  // Dispatch count
  output logic [2:0] dispatchCount
);

  // ==========================================================
  // Helpers
  // Pick a thread: alternate from last, skip one that cannot use the stage
  function automatic logic [1:0] pickThread(input logic [1:0] able, input logic last);
    logic [1:0] res;
    res = 2'h0;
    if (able == 2'h3) begin
      res = {1'h1, ~last};
    end else if (able[0]) begin
      res = 2'h2;
    end else if (able[1]) begin
      res = 2'h3;
    end
    return res;
  endfunction
  // Half of a partitioned buffer's entries
  function automatic int halfOf(input int idx);
    int n;
    n = ttp_pkg::UOPQ_ENTRIES;
    case (idx)
      ttp_pkg::BUF_RENQ: n = ttp_pkg::RENQ_ENTRIES;
      ttp_pkg::BUF_ROB: n = ttp_pkg::ROB_ENTRIES;
      ttp_pkg::BUF_LDB: n = ttp_pkg::LDB_ENTRIES;
      ttp_pkg::BUF_STB: n = ttp_pkg::STB_ENTRIES;
      default: n = ttp_pkg::UOPQ_ENTRIES;
    endcase
    return n / 2;
  endfunction
  // ==========================================================
  // Selection points
  logic lastFetch_reg;
  logic lastRetire_reg;
  logic lastStore_reg;
  logic [1:0] fetchPick;
  logic [1:0] retirePick;
  logic [1:0] storePick;
  // Not-ready threads lose their turn; a missing thread's slot goes to the other
  assign fetchPick = pickThread(fetchReq & ~fetchNotReady & threadActive, lastFetch_reg);
  assign retirePick = pickThread(retireReady & ~retireNotReady, lastRetire_reg);
  assign storePick = pickThread(storeReady & ~storeNotReady, lastStore_reg);
  assign fetchGrant = fetchPick[1];
  assign fetchThread = fetchPick[0];
  assign retireGrant = retirePick[1];
  assign retireThread = retirePick[0];
  assign storeGrant = storePick[1];
  assign storeThread = storePick[0];
  // Remember the last granted thread at each point
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastFetch_reg <= ttp_pkg::RR_RESET;
      lastRetire_reg <= ttp_pkg::RR_RESET;
      lastStore_reg <= ttp_pkg::RR_RESET;
    end else begin
      if (fetchPick[1]) lastFetch_reg <= fetchPick[0];
      if (retirePick[1]) lastRetire_reg <= retirePick[0];
      if (storePick[1]) lastStore_reg <= storePick[0];
    end
  end
  // ==========================================================
  // Replicated instruction pointers
  logic [ttp_pkg::IP_WIDTH-1:0] ip_reg [2];
  // Each thread's pointer moves only on its own load
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ip_reg[0] <= ttp_pkg::IP_RESET;
      ip_reg[1] <= ttp_pkg::IP_RESET;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (ipLoad[t]) ip_reg[t] <= ipLoadValue;
      end
    end
  end
  assign ip0 = ip_reg[0];
  assign ip1 = ip_reg[1];
  // ==========================================================
  // Replicated renaming tables
  logic [PREG_WIDTH-1:0] ren_reg [2][RENAME_REGS];
  logic [PREG_WIDTH-1:0] renRd_reg;
  // Tables indexed by thread so one thread never overwrites the other's map
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int t = 0; t < 2; t++) begin
        for (int r = 0; r < RENAME_REGS; r++) begin
          ren_reg[t][r] <= '0;
        end
      end
      renRd_reg <= '0;
    end else begin
      if (renWrite) ren_reg[renThread][renArch] <= renPhys;
      renRd_reg <= ren_reg[renRdThread][renRdArch];
    end
  end
  assign renRdPhys = renRd_reg;
  // ==========================================================
  // Return address stacks, one per thread
  logic [ttp_pkg::IP_WIDTH-1:0] ras_reg [2][RAS_DEPTH];
  logic [$clog2(RAS_DEPTH)-1:0] rasPtr_reg [2];
  // Circular stack; overflow silently drops the oldest entry
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int t = 0; t < 2; t++) begin
        rasPtr_reg[t] <= '0;
        for (int i = 0; i < RAS_DEPTH; i++) begin
          ras_reg[t][i] <= '0;
        end
      end
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (rasPush[t]) begin
          ras_reg[t][rasPtr_reg[t] + 1'h1] <= rasPushAddr;
          rasPtr_reg[t] <= rasPtr_reg[t] + 1'h1;
        end else if (rasPop[t]) begin
          rasPtr_reg[t] <= rasPtr_reg[t] - 1'h1;
        end
      end
    end
  end
  assign rasTop0 = ras_reg[0][rasPtr_reg[0]];
  assign rasTop1 = ras_reg[1][rasPtr_reg[1]];
  // ==========================================================
  // Private streaming buffers, occupancy only
  logic [1:0] sbCount_reg [2];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sbCount_reg[0] <= 2'h0;
      sbCount_reg[1] <= 2'h0;
    end else begin
      for (int t = 0; t < 2; t++) begin
        if (sbPush[t] && !sbFull[t] && !(sbPop[t] && sbCount_reg[t] != 2'h0)) begin
          sbCount_reg[t] <= sbCount_reg[t] + 2'h1;
        end else if (sbPop[t] && sbCount_reg[t] != 2'h0 && !(sbPush[t] && !sbFull[t])) begin
          sbCount_reg[t] <= sbCount_reg[t] - 2'h1;
        end
      end
    end
  end
  assign sbFull[0] = sbCount_reg[0] == 2'(ttp_pkg::STREAM_BUF_ENTRIES);
  assign sbFull[1] = sbCount_reg[1] == 2'(ttp_pkg::STREAM_BUF_ENTRIES);
  // ==========================================================
  // Partitioned buffer occupancy, capped at half per thread; the micro-op queue only while both threads run
  logic [5:0] occ0_reg [ttp_pkg::NUM_BUFS];
  logic [5:0] occ1_reg [ttp_pkg::NUM_BUFS];
  // Each thread keeps its own count; the half cap means a stalled thread cannot starve the other
  always_comb begin
    for (int b = 0; b < ttp_pkg::NUM_BUFS; b++) begin
      // Micro-op queue splits only when both threads run
      if (b == ttp_pkg::BUF_UOPQ && threadActive != 2'h3) begin
        allocOk0[b] = (occ0_reg[b] + occ1_reg[b]) < 6'(2 * halfOf(b));
        allocOk1[b] = (occ0_reg[b] + occ1_reg[b]) < 6'(2 * halfOf(b));
      end else begin
        allocOk0[b] = occ0_reg[b] < 6'(halfOf(b));
        allocOk1[b] = occ1_reg[b] < 6'(halfOf(b));
      end
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int b = 0; b < ttp_pkg::NUM_BUFS; b++) begin
        occ0_reg[b] <= 6'h00;
        occ1_reg[b] <= 6'h00;
      end
    end else begin
      for (int b = 0; b < ttp_pkg::NUM_BUFS; b++) begin
        occ0_reg[b] <= occ0_reg[b] + 6'(allocReq0[b] && allocOk0[b])
          - 6'(freeReq0[b] && occ0_reg[b] != 6'h00);
        occ1_reg[b] <= occ1_reg[b] + 6'(allocReq1[b] && allocOk1[b])
          - 6'(freeReq1[b] && occ1_reg[b] != 6'h00);
      end
    end
  end
  // ==========================================================
  // Ordering violation flags, one per thread half
  logic [1:0] ordViol_reg;
  // A violation in one thread's half never flags the other thread
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ordViol_reg <= 2'h0;
    end else begin
      ordViol_reg <= ordViolIn & {occ1_reg[ttp_pkg::BUF_LDB] != 6'h00,
        occ0_reg[ttp_pkg::BUF_LDB] != 6'h00};
    end
  end
  assign ordViolation = ordViol_reg;
  // ==========================================================
  // Translation buffer with thread tag
  logic [ttp_pkg::XLAT_ENTRIES-1:0] xlValid_reg;
  logic [ttp_pkg::XLAT_ENTRIES-1:0] xlThread_reg;
  logic [ttp_pkg::PAGE_WIDTH-1:0] xlPage_reg [ttp_pkg::XLAT_ENTRIES];
  logic [$clog2(ttp_pkg::XLAT_ENTRIES)-1:0] xlVictim_reg;
  logic xlHit_reg;
  logic xlHit_next;
  // Hit needs both page and owning thread to match
  always_comb begin
    xlHit_next = 1'h0;
    for (int e = 0; e < ttp_pkg::XLAT_ENTRIES; e++) begin
      if (xlValid_reg[e] && xlThread_reg[e] == xlatLookupThread && xlPage_reg[e] == xlatLookupPage) begin
        xlHit_next = xlatLookup;
      end
    end
  end
  // Round-robin replacement; simple and fair between threads
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xlValid_reg <= '0;
      xlThread_reg <= '0;
      xlVictim_reg <= '0;
      xlHit_reg <= 1'h0;
      for (int e = 0; e < ttp_pkg::XLAT_ENTRIES; e++) begin
        xlPage_reg[e] <= '0;
      end
    end else begin
      xlHit_reg <= xlHit_next;
      if (xlatFill) begin
        xlValid_reg[xlVictim_reg] <= 1'h1;
        xlThread_reg[xlVictim_reg] <= xlatFillThread;
        xlPage_reg[xlVictim_reg] <= xlatFillPage;
        xlVictim_reg <= xlVictim_reg + 1'h1;
      end
    end
  end
  assign xlatHit = xlHit_reg;
  // ==========================================================
  // Data cache mode and thread-blind dispatch
  logic dcMode_reg;
  logic [2:0] disp_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dcMode_reg <= ttp_pkg::TTP_DC_SHARED;
      disp_reg <= 3'h0;
    end else begin
      dcMode_reg <= contextIdBit;
      // Thread identity is not consulted here at all
      disp_reg <= (readyUops > 4'(ttp_pkg::DISPATCH_MAX)) ?
        3'(ttp_pkg::DISPATCH_MAX) : readyUops[2:0];
    end
  end
  assign dcAdaptive = dcMode_reg == ttp_pkg::TTP_DC_ADAPTIVE;
  assign dispatchCount = disp_reg;
endmodule

//--- dv/ttp_pipe_share_assertions.sv
// Concurrent checks on thread selection, dispatch count, cache mode and ordering flags
`timescale 1ns/100ps
module ttp_pipe_share_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched inputs
  input wire logic [1:0] fetchReq,
  input wire logic [1:0] fetchNotReady,
  input wire logic [1:0] threadActive,
  input wire logic [1:0] retireReady,
  input wire logic [1:0] retireNotReady,
  input wire logic [1:0] storeReady,
  input wire logic [1:0] storeNotReady,
  input wire logic [1:0] ordViolIn,
  input wire logic contextIdBit,
  input wire logic [3:0] readyUops,
  // Watched outputs
  input wire logic fetchGrant,
  input wire logic fetchThread,
  input wire logic retireGrant,
  input wire logic retireThread,
  input wire logic storeGrant,
  input wire logic storeThread,
  input wire logic [1:0] ordViolation,
  input wire logic dcAdaptive,
  input wire logic [2:0] dispatchCount
);
  // ==========================================================
  // Threads able to use each stage this cycle
  wire [1:0] fAble = fetchReq & ~fetchNotReady & threadActive;
  wire [1:0] rAble = retireReady & ~retireNotReady;
  wire [1:0] sAble = storeReady & ~storeNotReady;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Selection points
  property p_fetch_alt;
    fetchGrant && fAble == 2'h3 |=> fAble == 2'h3 |-> fetchThread != $past(fetchThread);
  endproperty
  a_fetch_alt: assert property (p_fetch_alt) else $error("fetch did not alternate");
  property p_fetch_skip;
    fAble == 2'h1 || fAble == 2'h2 |-> fetchGrant && fetchThread == fAble[1];
  endproperty
  a_fetch_skip: assert property (p_fetch_skip) else $error("fetch slot not handed over");
  property p_fetch_none;
    fAble == 2'h0 |-> !fetchGrant;
  endproperty
  a_fetch_none: assert property (p_fetch_none) else $error("fetch granted with no able thread");
  property p_retire_alt;
    retireGrant && rAble == 2'h3 |=> rAble == 2'h3 |-> retireThread != $past(retireThread);
  endproperty
  a_retire_alt: assert property (p_retire_alt) else $error("retire did not alternate");
  property p_retire_skip;
    rAble == 2'h1 || rAble == 2'h2 |-> retireGrant && retireThread == rAble[1];
  endproperty
  a_retire_skip: assert property (p_retire_skip) else $error("retire slot not handed over");
  property p_store_alt;
    storeGrant && sAble == 2'h3 |=> sAble == 2'h3 |-> storeThread != $past(storeThread);
  endproperty
  a_store_alt: assert property (p_store_alt) else $error("store commit did not alternate");
  // ==========================================================
  // Registered outputs, one cycle after their cause
  property p_dispatch;
    nrst |=> dispatchCount == ($past(readyUops) > 4'h6 ? 3'h6 : $past(readyUops[2:0]));
  endproperty
  a_dispatch: assert property (p_dispatch) else $error("dispatch count wrong");
  property p_dc_mode;
    nrst |=> dcAdaptive == $past(contextIdBit);
  endproperty
  a_dc_mode: assert property (p_dc_mode) else $error("cache mode not following context bit");
  property p_ord_quiet;
    nrst && ordViolIn == 2'h0 |=> ordViolation == 2'h0;
  endproperty
  a_ord_quiet: assert property (p_ord_quiet) else $error("ordering flag without cause");
endmodule

bind ttp_pipe_share ttp_pipe_share_assertions u_chk (.clk(clk), .nrst(nrst), .fetchReq(fetchReq),
  .fetchNotReady(fetchNotReady), .threadActive(threadActive), .retireReady(retireReady),
  .retireNotReady(retireNotReady), .storeReady(storeReady), .storeNotReady(storeNotReady),
  .ordViolIn(ordViolIn), .contextIdBit(contextIdBit), .readyUops(readyUops), .fetchGrant(fetchGrant),
  .fetchThread(fetchThread), .retireGrant(retireGrant), .retireThread(retireThread),
  .storeGrant(storeGrant), .storeThread(storeThread), .ordViolation(ordViolation),
  .dcAdaptive(dcAdaptive), .dispatchCount(dispatchCount));

//--- dv/test_two_thread_pipeline_sharing.sv
// Self-checking bench for the two-thread pipeline sharing control
`timescale 1ns/100ps
module test_two_thread_pipeline_sharing;
  // ==========================================================
  // Stimulus and observed signals
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [1:0] fetchReq = '0, fetchNotReady = '0, retireReady = '0, retireNotReady = '0;
  logic [1:0] storeReady = '0, storeNotReady = '0, threadActive = 2'h3, ipLoad = '0;
  logic [1:0] rasPush = '0, rasPop = '0, sbPush = '0, sbPop = '0, ordViolIn = '0;
  logic [31:0] ipLoadValue = '0, rasPushAddr = '0;
  logic renWrite = 1'h0, renThread = 1'h0, renRdThread = 1'h0, xlatFill = 1'h0, xlatFillThread = 1'h0;
  logic xlatLookup = 1'h0, xlatLookupThread = 1'h0, contextIdBit = 1'h0;
  logic [2:0] renArch = '0, renRdArch = '0;
  logic [6:0] renPhys = '0, renRdPhys;
  logic [4:0] allocReq0 = '0, allocReq1 = '0, freeReq0 = '0, freeReq1 = '0, allocOk0, allocOk1;
  logic [19:0] xlatFillPage = '0, xlatLookupPage = '0;
  logic [3:0] readyUops = '0;
  logic fetchGrant, fetchThread, retireGrant, retireThread, storeGrant, storeThread, xlatHit, dcAdaptive;
  logic [31:0] ip0, ip1, rasTop0, rasTop1;
  logic [1:0] sbFull, ordViolation;
  logic [2:0] dispatchCount;
  int mismatches = 0;
  int totalChecks = 0;

  // Free-running 125 MHz clock
  always #4 clk = ~clk;

  ttp_pipe_share DUT (.clk(clk), .nrst(nrst), .fetchReq(fetchReq), .fetchNotReady(fetchNotReady),
    .retireReady(retireReady), .retireNotReady(retireNotReady), .storeReady(storeReady),
    .storeNotReady(storeNotReady), .threadActive(threadActive), .ipLoad(ipLoad), .ipLoadValue(ipLoadValue),
    .rasPush(rasPush), .rasPop(rasPop), .rasPushAddr(rasPushAddr), .renWrite(renWrite), .renThread(renThread),
    .renArch(renArch), .renPhys(renPhys), .renRdThread(renRdThread), .renRdArch(renRdArch),
    .allocReq0(allocReq0), .allocReq1(allocReq1), .freeReq0(freeReq0), .freeReq1(freeReq1), .sbPush(sbPush),
    .sbPop(sbPop), .ordViolIn(ordViolIn), .xlatFill(xlatFill), .xlatFillThread(xlatFillThread),
    .xlatFillPage(xlatFillPage), .xlatLookup(xlatLookup), .xlatLookupThread(xlatLookupThread),
    .xlatLookupPage(xlatLookupPage), .contextIdBit(contextIdBit), .readyUops(readyUops),
    .fetchGrant(fetchGrant), .fetchThread(fetchThread), .retireGrant(retireGrant), .retireThread(retireThread),
    .storeGrant(storeGrant), .storeThread(storeThread), .ip0(ip0), .ip1(ip1), .rasTop0(rasTop0),
    .rasTop1(rasTop1), .renRdPhys(renRdPhys), .allocOk0(allocOk0), .allocOk1(allocOk1), .sbFull(sbFull),
    .ordViolation(ordViolation), .xlatHit(xlatHit), .dcAdaptive(dcAdaptive), .dispatchCount(dispatchCount));

  // ==========================================================
  // Comparison and verdict
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic endOfTest();
    if (mismatches == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Alternation, yielding and skipping at all three selection points
  task automatic sc_select();
    logic [1:0] req [8] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h1, 2'h0};
    logic [1:0] nr [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h3, 2'h0, 2'h0};
    logic thr [8] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0};
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      fetchReq = req[i];
      retireReady = req[i];
      storeReady = req[i];
      fetchNotReady = nr[i];
      retireNotReady = nr[i];
      storeNotReady = nr[i];
      #1;
      chk("fetchGrant", fetchGrant, i < 5 || i == 6);
      chk("retireGrant", retireGrant, i < 5 || i == 6);
      chk("storeGrant", storeGrant, i < 5 || i == 6);
      if (i < 5 || i == 6) begin
        chk("fetchThread", fetchThread, thr[i]);
        chk("retireThread", retireThread, thr[i]);
        chk("storeThread", storeThread, thr[i]);
      end
    end
    // An inactive thread never takes a fetch slot, even when it is its turn
    @(negedge clk);
    fetchReq = 2'h3;
    threadActive = 2'h1;
    #1;
    chk("fetchGrant", fetchGrant, 1);
    chk("fetchThread", fetchThread, 0);
    @(negedge clk);
    threadActive = 2'h3;
    fetchReq = 2'h0;
  endtask

  // Per-thread instruction pointer, return stack and rename table
  task automatic sc_state();
    @(negedge clk);
    ipLoad = 2'h1;
    ipLoadValue = 32'h1000_0040;
    rasPush = 2'h1;
    rasPushAddr = 32'h2000_0010;
    renWrite = 1;
    renArch = 3'h3;
    renPhys = 7'h05;
    @(negedge clk);
    ipLoad = 2'h2;
    ipLoadValue = 32'h3000_0080;
    rasPush = 2'h2;
    rasPushAddr = 32'h4000_0020;
    renThread = 1;
    renPhys = 7'h09;
    @(negedge clk);
    ipLoad = 2'h0;
    rasPush = 2'h0;
    renWrite = 0;
    rasPop = 2'h2;
    renRdArch = 3'h3;
    chk("ip0", ip0, 32'h1000_0040);
    chk("ip1", ip1, 32'h3000_0080);
    chk("rasTop1", rasTop1, 32'h4000_0020);
    @(negedge clk);
    rasPop = 2'h0;
    renRdThread = 1;
    chk("rasTop0", rasTop0, 32'h2000_0010);
    chk("rasTop1", rasTop1, 32'h0);
    chk("renRdPhys", renRdPhys, 7'h05);
    @(negedge clk);
    chk("renRdPhys", renRdPhys, 7'h09);
  endtask

  // Half-entry caps, private streaming buffer and per-thread ordering
  task automatic sc_partition();
    for (int i = 0; i < 17; i++) begin
      @(negedge clk);
      chk("allocOk0", allocOk0, {i < 8, i < 8, i < 16, i < 8, i < 8});
      chk("allocOk1", allocOk1, 5'h1f);
      chk("sbFull", sbFull, (i >= 2) ? 2'h1 : 2'h0);
      allocReq0 = (i < 16) ? 5'h1f : 5'h00;
      sbPush = (i < 2) ? 2'h1 : 2'h0;
    end
    // With one thread running, the capped thread may fill the whole micro-op queue
    ordViolIn = 2'h3;
    threadActive = 2'h1;
    #1;
    chk("allocOk0", allocOk0, 5'h01);
    @(negedge clk);
    ordViolIn = 2'h0;
    threadActive = 2'h3;
    chk("ordViolation", ordViolation, 2'h1);
    freeReq0 = 5'h1f;
    sbPop = 2'h1;
    repeat (16) @(negedge clk);
    freeReq0 = 5'h0;
    sbPop = 2'h0;
    chk("allocOk0", allocOk0, 5'h1f);
    chk("sbFull", sbFull, 2'h0);
  endtask

  // Thread-tagged translation lookups
  task automatic sc_xlat();
    @(negedge clk);
    xlatFill = 1;
    xlatFillPage = 20'h00abc;
    @(negedge clk);
    xlatFill = 0;
    xlatLookup = 1;
    xlatLookupPage = 20'h00abc;
    @(negedge clk);
    xlatLookupThread = 1;
    chk("xlatHit", xlatHit, 1);
    @(negedge clk);
    xlatLookup = 0;
    chk("xlatHit", xlatHit, 0);
  endtask

  // Dispatch ceiling and cache mode over every ready count
  task automatic sc_dispatch();
    for (int i = 0; i < 17; i++) begin
      @(negedge clk);
      if (i > 0) begin
        chk("dispatchCount", dispatchCount, (i - 1 > 6) ? 6 : i - 1);
        chk("dcAdaptive", dcAdaptive, (i - 1) % 2);
      end
      readyUops = 4'(i);
      contextIdBit = i[0];
    end
  endtask

  // Hang guard, well past the whole sequence
  initial begin
    #100000;
    mismatches++;
    endOfTest();
  end

  // Reset for two cycles, then every scenario in turn
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'h1;
    sc_select();
    sc_state();
    sc_partition();
    sc_xlat();
    sc_dispatch();
    endOfTest();
  end
endmodule
